//--- sscr_pkg.sv
/*
 * sscr_pkg: shared constants of the safety state command register bank:
 * register offsets, field positions, values after reset, state codes
 * and identification fields.
 * Assumes a 32-bit classic Wishbone bus with byte addresses, one word a register.
 */
package sscr_pkg;

    // bus geometry
    localparam int ADR_W = 5;
    localparam int DAT_W = 32;
    localparam int REG_W = 16;
    localparam int STATE_W = 5;

    // register byte offsets
    localparam logic [ADR_W-1:0] OFS_FAULT_CFG = 5'h00;
    localparam logic [ADR_W-1:0] OFS_FAULT_CFG_INV = 5'h04;
    localparam logic [ADR_W-1:0] OFS_STATE_CMD = 5'h08;
    localparam logic [ADR_W-1:0] OFS_STATE_CMD_INV = 5'h0c;
    localparam logic [ADR_W-1:0] OFS_FSM_STATUS = 5'h10;
    localparam logic [ADR_W-1:0] OFS_CHIP_ID = 5'h14;

    // fault input configuration field positions
    localparam int POS_PAIR_POL = 14;
    localparam int POS_FIRST_POL = 13;
    localparam int POS_SECOND_POL = 12;
    localparam int POS_BISTABLE = 8;
    localparam logic [REG_W-1:0] CFG_MASK = 16'h7100;

    // state command field positions
    localparam int POS_DEBUG_RELEASE = 15;
    localparam int POS_ENTER_INIT_RUN = 1;
    localparam int POS_ENTER_NORMAL = 0;
    localparam logic [1:0] CMD_RST = 2'h0;
    localparam logic [1:0] CMD_INV_RST = 2'h0;

    // values after reset: settings 0, complements 1, so consistent
    localparam logic [REG_W-1:0] CFG_RST = 16'h0000;
    localparam logic [REG_W-1:0] CFG_INV_RST = 16'h7100;

    // main state field codes
    localparam logic [STATE_W-1:0] ST_SELF_TEST = 5'h04;
    localparam logic [STATE_W-1:0] ST_POWER_UP = 5'h05;
    localparam logic [STATE_W-1:0] ST_DEEP_FAIL_SAFE = 5'h08;
    localparam logic [STATE_W-1:0] ST_INIT_RUN = 5'h09;
    localparam logic [STATE_W-1:0] ST_NORMAL = 5'h0c;
    localparam logic [STATE_W-1:0] ST_THERMAL_SHUTDOWN = 5'h0d;
    localparam logic [STATE_W-1:0] ST_POWER_DOWN = 5'h10;
    localparam logic [STATE_W-1:0] ST_POWER_ON_RESET = 5'h11;

    // identification fields; all values arbitrary
    localparam logic [2:0] ID_FULL_LAYER_REVISION = 3'h1;
    localparam logic [2:0] ID_METAL_LAYER_REVISION = 3'h2;
    localparam logic [3:0] ID_FAMILY_CODE = 4'h5;
    localparam logic [3:0] ID_VARIANT_CODE = 4'h3;

    // synchroniser depth and idle level of the output flops
    localparam int SYNC_STAGES = 2;
    localparam logic FAULT_RST = 1'b0;

endpackage

//--- sscr_sync.sv
/*
 * sscr_sync: two-flop synchroniser for the fault input pins.
 * Assumes the pins are asynchronous to clk_i; only the second flop is read.
 */
`timescale 1ns/1ps
module sscr_sync
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // pins in, synchronised levels out
    input wire logic [1:0] pin_i,
    output logic [1:0] sync_o
);
    import sscr_pkg::*;

    logic [1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta <= 2'h0;
            sync_o <= 2'h0;
        end
        else if (ce_i)
        begin
            meta <= pin_i;
            sync_o <= meta;
        end
    end

endmodule // sscr_sync

//--- sscr_fault_eval.sv
/*
 * sscr_fault_eval: turns the two synchronised fault input levels into
 * fault flags under the applied polarity and bistable settings.
 * Assumes settings already gated by the complement check upstream.
 */
`timescale 1ns/1ps
module sscr_fault_eval
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // synchronised input levels
    input wire logic first_in_i,
    input wire logic second_in_i,
    // applied settings
    input wire logic pair_fault_polarity_i,
    input wire logic first_input_polarity_i,
    input wire logic second_input_polarity_i,
    input wire logic pair_bistable_enable_i,
    // fault flags
    output logic first_fault_o,
    output logic second_fault_o,
    output logic pair_fault_o
);
    import sscr_pkg::*;

    // single inputs: polarity 1 means high is a fault
    wire first_bad = first_input_polarity_i ? first_in_i : ~first_in_i; // [R4]
    wire second_bad = second_input_polarity_i ? second_in_i : ~second_in_i; // [R4]
    // pair: polarity 0 flags first low or second high
    wire pair_bad = pair_fault_polarity_i ? (first_in_i | ~second_in_i)
                                          : (~first_in_i | second_in_i); // [R3]

    // bistable mode uses the pair check, else the two stand alone
    wire next_first = ~pair_bistable_enable_i & first_bad; // [R4]
    wire next_second = ~pair_bistable_enable_i & second_bad; // [R4]
    wire next_pair = pair_bistable_enable_i & pair_bad; // [R4]

    // flags leave on flops so they never glitch
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            first_fault_o <= FAULT_RST;
            second_fault_o <= FAULT_RST;
            pair_fault_o <= FAULT_RST;
        end
        else if (ce_i)
        begin
            first_fault_o <= next_first;
            second_fault_o <= next_second;
            pair_fault_o <= next_pair;
        end
    end

endmodule // sscr_fault_eval

//--- sscr_top.sv
/*
 * sscr_top: safety state command register bank with a classic Wishbone
 * slave, the fault input configuration and its complement, state commands
 * with their complement, main state readback and identification.
 *
 * Register map, one 16-bit register in the low half of each 32-bit word:
 *   0x00  fault input configuration, bits 14, 13, 12 and 8
 *   0x04  its complement, the same four bits
 *   0x08  state command: debug release 15, enter init run 1, enter normal 0
 *   0x0c  state command complement, bits 1 and 0
 *   0x10  main state code in bits 4 to 0, read only
 *   0x14  identity fields, read only
 * Any other address reads zero and ignores writes, but is still acked.
 * Undefined bits of a defined register read zero and ignore writes.
 *
 * Values after reset: configuration 0, its complement 0x7100, so the pair
 * is consistent from the start; commands and their complements 0.
 *
 * Bus timing: a request is taken at the rising edge that sees cyc and stb
 * high with ack low; a write lands at that edge, ack and read data stand
 * for the next cycle only, and ack is then low for a cycle even if stb is
 * still held, so a held strobe becomes a second access.
 *
 * Fault flags follow a pin change three edges later: two synchroniser
 * flops and the output flop. A setting changed in one register only keeps
 * its old applied value until the complement agrees; the applied copy lags
 * consistency by one cycle.
 *
 * Assumes the main state machine runs on clk_i and reports its code on
 * fsm_state_i, so that code is read without synchronising; the fault
 * input pins are asynchronous. ce_i low freezes every flop, ack included,
 * so a pending request simply waits.
 * Assumes the master drives byte lanes 1 and 0 only; lanes 3 and 2 are
 * ignored. Bit 15 of the state command is a strobe and is not stored, so
 * it always reads zero.
 */
// The Wishbone slave port and the register offsets are this design's own decisions.
// What this block does
// R1: the configuration complement holds writable inverse bits 14, 13, 12 and 8, set to a known value, 0x7100, at reset.
// R2: a fault input setting is used only while it equals the inverse of its complement bit.
// R3: pair polarity 0 flags first low or second high, 1 flags first high or second low.
// R4: single polarity 0 flags low, 1 flags high; bistable enable 1 pairs the inputs, 0 keeps them apart.
// R5: writing 1 to state command bit 15 releases debug mode, writing 0 does nothing.
// R6: the enter init run command at bit 1 acts only when it equals the inverse of its complement.
// R7: an applied enter init run command in normal moves to init run and self-clears there.
// R8: the enter normal command at bit 0 acts only when it equals the inverse of its complement.
// R9: an applied enter normal command in init run moves to normal and self-clears there.
// R10: the state command complement holds writable inverse bits 1 and 0, reset at power-on.
// R11: the status register reports the 5-bit main state code.
// R12: the identity register shows full and metal layer revisions, family code and variant code.
// R13: writes to undefined bits are ignored and they read as zero.
`timescale 1ns/1ps
module sscr_top
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [sscr_pkg::ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [sscr_pkg::DAT_W-1:0] dat_i,
    output logic [sscr_pkg::DAT_W-1:0] dat_o,
    output logic ack_o,
    // main state machine link
    input wire logic [sscr_pkg::STATE_W-1:0] fsm_state_i,
    output logic enter_init_run_o,
    output logic enter_normal_o,
    output logic debug_release_o,
    // fault input pins
    input wire logic first_fault_pin_i,
    input wire logic second_fault_pin_i,
    // fault flags
    output logic first_fault_o,
    output logic second_fault_o,
    output logic pair_fault_o,
    // applied settings
    output logic pair_fault_polarity_o,
    output logic first_input_polarity_o,
    output logic second_input_polarity_o,
    output logic pair_bistable_enable_o
);
    import sscr_pkg::*;

    // register state
    logic ack;
    logic [REG_W-1:0] fault_cfg;
    logic [REG_W-1:0] fault_cfg_inv;
    logic [REG_W-1:0] cfg_applied;
    logic [1:0] state_cmd;
    logic [1:0] state_cmd_inv;
    logic [DAT_W-1:0] rdata;
    logic [1:0] pins_sync;

    // bus request decode
    wire bus_req = cyc_i & stb_i;
    wire bus_take = bus_req & ~ack;
    wire bus_wr = bus_take & we_i;
    wire hit_cfg = (adr_i == OFS_FAULT_CFG);
    wire hit_cfg_inv = (adr_i == OFS_FAULT_CFG_INV);
    wire hit_cmd = (adr_i == OFS_STATE_CMD);
    wire hit_cmd_inv = (adr_i == OFS_STATE_CMD_INV);
    wire hit_status = (adr_i == OFS_FSM_STATUS);
    wire hit_id = (adr_i == OFS_CHIP_ID);

    // byte lanes; upper half of the word holds nothing
    wire [REG_W-1:0] lane_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
    wire [REG_W-1:0] wr_data = dat_i[REG_W-1:0];
    wire lane_lo = sel_i[0];
    wire lane_hi = sel_i[1];

    // configuration writes keep only the four defined bits
    wire [REG_W-1:0] cfg_wmask = lane_mask & CFG_MASK; // [R13]
    wire wr_cfg = bus_wr & hit_cfg;
    wire wr_cfg_inv = bus_wr & hit_cfg_inv;
    wire [REG_W-1:0] next_fault_cfg = (fault_cfg & ~cfg_wmask) | (wr_data & cfg_wmask);
    wire [REG_W-1:0] next_fault_cfg_inv = (fault_cfg_inv & ~cfg_wmask) | (wr_data & cfg_wmask); // [R1]

    // a setting is consistent when it differs from its complement bit
    wire [REG_W-1:0] cfg_consistent = (fault_cfg ^ fault_cfg_inv) & CFG_MASK; // [R2]
    // inconsistent bits keep their last applied value
    wire [REG_W-1:0] next_cfg_applied = (cfg_applied & ~cfg_consistent) | (fault_cfg & cfg_consistent); // [R2]

    // state command writes on the low lane
    wire wr_cmd = bus_wr & hit_cmd & lane_lo;
    wire wr_cmd_inv = bus_wr & hit_cmd_inv & lane_lo;
    wire set_init = wr_cmd & wr_data[POS_ENTER_INIT_RUN];
    wire set_normal = wr_cmd & wr_data[POS_ENTER_NORMAL];

    // debug release is a write-one strobe, a zero does nothing
    wire next_debug_release = bus_wr & hit_cmd & lane_hi & wr_data[POS_DEBUG_RELEASE]; // [R5]

    // main state decode
    wire in_normal = (fsm_state_i == ST_NORMAL);
    wire in_init_run = (fsm_state_i == ST_INIT_RUN);

    // a command counts only when its complement bit is its inverse
    wire init_cmd_valid = state_cmd[POS_ENTER_INIT_RUN] & ~state_cmd_inv[POS_ENTER_INIT_RUN]; // [R6]
    wire normal_cmd_valid = state_cmd[POS_ENTER_NORMAL] & ~state_cmd_inv[POS_ENTER_NORMAL]; // [R8]

    // requests to the state machine, only from the matching state
    wire next_enter_init_run = init_cmd_valid & in_normal; // [R7]
    wire next_enter_normal = normal_cmd_valid & in_init_run; // [R9]

    // self-clear on arrival; a fresh write in the same cycle wins
    wire clr_init = in_init_run & ~set_init; // [R7]
    wire clr_normal = in_normal & ~set_normal; // [R9]

    // next command bits: written value, else held, then self-clear
    wire next_cmd_init = wr_cmd ? wr_data[POS_ENTER_INIT_RUN]
                                : (state_cmd[POS_ENTER_INIT_RUN] & ~clr_init);
    wire next_cmd_normal = wr_cmd ? wr_data[POS_ENTER_NORMAL]
                                  : (state_cmd[POS_ENTER_NORMAL] & ~clr_normal);
    wire [1:0] next_state_cmd = {next_cmd_init, next_cmd_normal};

    // complement bits are plain storage
    wire [1:0] next_state_cmd_inv = wr_cmd_inv ? wr_data[1:0] : state_cmd_inv; // [R10]

    // read views; undefined positions read as zero
    wire [REG_W-1:0] view_cfg = fault_cfg & CFG_MASK; // [R13]
    wire [REG_W-1:0] view_cfg_inv = fault_cfg_inv & CFG_MASK; // [R1]
    wire [REG_W-1:0] view_cmd = {14'h0000, state_cmd}; // [R13]
    wire [REG_W-1:0] view_cmd_inv = {14'h0000, state_cmd_inv}; // [R10]
    wire [REG_W-1:0] view_status = {11'h000, fsm_state_i}; // [R11]
    wire [REG_W-1:0] view_id = {2'h0, ID_FULL_LAYER_REVISION, ID_METAL_LAYER_REVISION,
                                ID_FAMILY_CODE, ID_VARIANT_CODE}; // [R12]

    // read mux; unmapped addresses answer with zero
    wire [REG_W-1:0] read_sel = hit_cfg ? view_cfg :
                                hit_cfg_inv ? view_cfg_inv :
                                hit_cmd ? view_cmd :
                                hit_cmd_inv ? view_cmd_inv :
                                hit_status ? view_status :
                                hit_id ? view_id : 16'h0000;
    wire [DAT_W-1:0] next_rdata = (bus_take & ~we_i) ? {16'h0000, read_sel} : 32'h0000_0000;

    // every access, mapped or not, gets one ack a cycle later
    wire next_ack = bus_take;

    // inputs from the pins pass two flops before anything reads them
    sscr_sync u_sync
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .pin_i({second_fault_pin_i, first_fault_pin_i}),
        .sync_o(pins_sync)
    );

    // fault flags follow the applied settings only
    sscr_fault_eval u_fault_eval
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .first_in_i(pins_sync[0]),
        .second_in_i(pins_sync[1]),
        .pair_fault_polarity_i(cfg_applied[POS_PAIR_POL]),
        .first_input_polarity_i(cfg_applied[POS_FIRST_POL]),
        .second_input_polarity_i(cfg_applied[POS_SECOND_POL]),
        .pair_bistable_enable_i(cfg_applied[POS_BISTABLE]),
        .first_fault_o(first_fault_o),
        .second_fault_o(second_fault_o),
        .pair_fault_o(pair_fault_o)
    );

    // bus handshake; ack low again after one cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack <= 1'b0;
        else if (ce_i)
            ack <= next_ack;
    end

    // read data stands only in the ack cycle, zero otherwise
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata <= 32'h0000_0000;
        else if (ce_i)
            rdata <= next_rdata;
    end

    // fault configuration and its complement
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fault_cfg <= CFG_RST;
            fault_cfg_inv <= CFG_INV_RST; // [R1]
        end
        else if (ce_i)
        begin
            if (wr_cfg)
                fault_cfg <= next_fault_cfg;
            if (wr_cfg_inv)
                fault_cfg_inv <= next_fault_cfg_inv; // [R1]
        end
    end

    // applied copy; reset value matches the consistent reset pair
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cfg_applied <= CFG_RST;
        else if (ce_i)
            cfg_applied <= next_cfg_applied; // [R2]
    end

    // state commands and their complements
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_cmd <= CMD_RST;
            state_cmd_inv <= CMD_INV_RST; // [R10]
        end
        else if (ce_i)
        begin
            state_cmd <= next_state_cmd;
            state_cmd_inv <= next_state_cmd_inv;
        end
    end

    // init run request, a level while the command is applied in normal
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            enter_init_run_o <= 1'b0;
        else if (ce_i)
            enter_init_run_o <= next_enter_init_run; // [R7]
    end

    // normal request, a level while the command is applied in init run
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            enter_normal_o <= 1'b0;
        else if (ce_i)
            enter_normal_o <= next_enter_normal; // [R9]
    end

    // debug release, one cycle per write of one; nothing is stored
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            debug_release_o <= 1'b0;
        else if (ce_i)
            debug_release_o <= next_debug_release; // [R5]
    end

    // bus outputs straight from flops
    assign ack_o = ack;
    assign dat_o = rdata;

    // applied settings shown to the rest of the chip
    assign pair_fault_polarity_o = cfg_applied[POS_PAIR_POL];
    assign first_input_polarity_o = cfg_applied[POS_FIRST_POL];
    assign second_input_polarity_o = cfg_applied[POS_SECOND_POL];
    assign pair_bistable_enable_o = cfg_applied[POS_BISTABLE];

endmodule // sscr_top

//--- sscr_checker.sv
/*
 * sscr_checker: concurrent checks on the ports of the safety state command
 * register bank. Assumes ce_i stays high and one clock domain on clk_i.
 */
`timescale 1ns/1ps
module sscr_checker
    import sscr_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [sscr_pkg::ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [sscr_pkg::DAT_W-1:0] dat_i,
    input wire logic [sscr_pkg::DAT_W-1:0] dat_o,
    input wire logic ack_o,
    // main state machine link
    input wire logic [sscr_pkg::STATE_W-1:0] fsm_state_i,
    input wire logic enter_init_run_o,
    input wire logic enter_normal_o,
    input wire logic debug_release_o
);
    // a request the slave takes at this edge
    wire logic take = cyc_i & stb_i & ~ack_o & ce_i;
    wire logic take_rd = take & ~we_i;
    wire logic dbg_wr = take & we_i & (adr_i == OFS_STATE_CMD) & sel_i[1] & dat_i[15];

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // bus handshake, one registered ack per request
    chk_ack_answer: assert property (take |=> ack_o) else $error("ack missing after request");
    chk_ack_single: assert property (ack_o && ce_i |=> !ack_o) else $error("ack longer than one cycle");
    chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
    // undefined upper half never driven
    chk_upper_zero: assert property (dat_o[31:16] == 16'h0000) else $error("upper read bits not zero");
    // readback of fixed and live fields
    chk_id_value: assert property (take_rd && adr_i == OFS_CHIP_ID |=>
        dat_o == {18'h0, ID_FULL_LAYER_REVISION, ID_METAL_LAYER_REVISION, ID_FAMILY_CODE, ID_VARIANT_CODE})
        else $error("identity read wrong");
    chk_status_value: assert property (take_rd && adr_i == OFS_FSM_STATUS |=>
        dat_o == {27'h0, $past(fsm_state_i)})
        else $error("state field read wrong");
    // debug release pulse only from a write of one to bit 15
    chk_debug_pulse: assert property (dbg_wr |=> debug_release_o ##1 !debug_release_o)
        else $error("debug release pulse wrong");
    chk_debug_cause: assert property (debug_release_o |-> $past(dbg_wr)) else $error("debug release uncaused");
    // state commands act only from their source state
    chk_init_cause: assert property (enter_init_run_o |-> $past(fsm_state_i) == ST_NORMAL)
        else $error("init run request outside normal");
    chk_normal_cause: assert property (enter_normal_o |-> $past(fsm_state_i) == ST_INIT_RUN)
        else $error("normal request outside init run");
endmodule // sscr_checker

bind sscr_top sscr_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .fsm_state_i(fsm_state_i), .enter_init_run_o(enter_init_run_o), .enter_normal_o(enter_normal_o),
    .debug_release_o(debug_release_o));

//--- tb.sv
/*
 * tb: self-checking bench for the safety state command register bank.
 * Assumes the bind of sscr_checker; the bench plays bus master, state machine and pins.
 */
`timescale 1ns/1ps
module tb;
    import sscr_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [ADR_W-1:0] adr_i = 5'h00;
    logic [3:0] sel_i = 4'h3;
    logic [DAT_W-1:0] dat_i = 32'h0;
    logic [STATE_W-1:0] fsm_state_i = ST_POWER_ON_RESET;
    logic pin1 = 1'b0;
    logic pin2 = 1'b0;
    wire logic [DAT_W-1:0] dat_o;
    wire logic ack_o, init_o, normal_o, dbg_o, f1_o, f2_o, fp_o, pp_o, p1_o, p2_o, bi_o;
    int err_count = 0;
    int checks = 0;
    int dbg_pulses = 0;

    sscr_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .fsm_state_i(fsm_state_i),
        .enter_init_run_o(init_o), .enter_normal_o(normal_o), .debug_release_o(dbg_o),
        .first_fault_pin_i(pin1), .second_fault_pin_i(pin2), .first_fault_o(f1_o), .second_fault_o(f2_o),
        .pair_fault_o(fp_o), .pair_fault_polarity_o(pp_o), .first_input_polarity_o(p1_o),
        .second_input_polarity_o(p2_o), .pair_bistable_enable_o(bi_o));

    // 50 MHz clock
    initial
    begin
        forever #10 clk_i = ~clk_i;
    end

    // count debug release pulses, each seen at one falling edge
    always @(negedge clk_i)
    begin
        if (dbg_o === 1'b1)
            dbg_pulses++;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // classic single cycle: hold until ack is seen at a rising edge
    task automatic xfer(input logic [4:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 20)
            chk("ack", {31'h0, ack_o}, 32'h1);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask

    task automatic rdc(input string name, input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(a, 1'b0, 32'h0, q);
        chk(name, q, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic t_reset_regs;
        rdc("cfg", OFS_FAULT_CFG, 32'h0);
        rdc("cfg_inv", OFS_FAULT_CFG_INV, 32'h7100);
        rdc("cmd", OFS_STATE_CMD, 32'h0);
        rdc("cmd_inv", OFS_STATE_CMD_INV, 32'h0);
        wr(OFS_CHIP_ID, 32'hffffffff);
        rdc("id", OFS_CHIP_ID, {18'h0, ID_FULL_LAYER_REVISION, ID_METAL_LAYER_REVISION, ID_FAMILY_CODE, ID_VARIANT_CODE});
        wr(5'h18, 32'hffffffff);
        rdc("unmapped", 5'h18, 32'h0);
        chk("settings", {28'h0, pp_o, p1_o, p2_o, bi_o}, 32'h0);
    endtask

    // table of settings and pin levels with the flags they must raise
    task automatic t_fault_cfg;
        logic [15:0] cfg [8] = '{16'h7100, 16'h7100, 16'h7100, 16'h0100, 16'h0100, 16'h0100, 16'h3000, 16'h0000};
        logic [1:0] pins [8] = '{2'b11, 2'b01, 2'b00, 2'b00, 2'b10, 2'b11, 2'b10, 2'b00};
        logic [2:0] flt [8] = '{3'b001, 3'b000, 3'b001, 3'b001, 3'b000, 3'b001, 3'b100, 3'b110};
        wr(OFS_FAULT_CFG_INV, 32'hffffffff);
        rdc("cfg_inv", OFS_FAULT_CFG_INV, 32'h7100);
        wr(OFS_FAULT_CFG, 32'h7100);
        idle(4);
        chk("inconsistent", {28'h0, pp_o, p1_o, p2_o, bi_o}, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            wr(OFS_FAULT_CFG, {16'h0, cfg[i]});
            wr(OFS_FAULT_CFG_INV, {16'h0, ~cfg[i] & 16'h7100});
            @(posedge clk_i);
            pin1 <= pins[i][1];
            pin2 <= pins[i][0];
            idle(6);
            chk("applied", {28'h0, pp_o, p1_o, p2_o, bi_o}, {28'h0, cfg[i][14:12], cfg[i][8]});
            chk("faults", {29'h0, f1_o, f2_o, fp_o}, {29'h0, flt[i]});
        end
    endtask

    task automatic t_state_cmd;
        @(posedge clk_i);
        fsm_state_i <= ST_NORMAL;
        wr(OFS_STATE_CMD_INV, 32'hffffffff);
        rdc("cmd_inv", OFS_STATE_CMD_INV, 32'h3);
        wr(OFS_STATE_CMD, 32'h2);
        idle(3);
        chk("init_refused", {31'h0, init_o}, 32'h0);
        wr(OFS_STATE_CMD_INV, 32'h1);
        idle(2);
        chk("init_req", {31'h0, init_o}, 32'h1);
        @(posedge clk_i);
        fsm_state_i <= ST_INIT_RUN;
        idle(3);
        chk("init_done", {31'h0, init_o}, 32'h0);
        rdc("cmd_clr1", OFS_STATE_CMD, 32'h0);
        wr(OFS_STATE_CMD, 32'h1);
        idle(3);
        chk("normal_refused", {31'h0, normal_o}, 32'h0);
        wr(OFS_STATE_CMD_INV, 32'h0);
        idle(2);
        chk("normal_req", {31'h0, normal_o}, 32'h1);
        @(posedge clk_i);
        fsm_state_i <= ST_NORMAL;
        idle(3);
        chk("normal_done", {31'h0, normal_o}, 32'h0);
        rdc("cmd_clr0", OFS_STATE_CMD, 32'h0);
    endtask

    task automatic t_debug;
        int n0;
        n0 = dbg_pulses;
        wr(OFS_STATE_CMD, 32'h8000);
        wr(OFS_STATE_CMD, 32'h0);
        idle(2);
        chk("dbg_pulses", dbg_pulses - n0, 32'h1);
        @(posedge clk_i);
        sel_i <= 4'h1;
        wr(OFS_STATE_CMD, 32'h8000);
        @(posedge clk_i);
        sel_i <= 4'h3;
        idle(2);
        chk("dbg_lane_off", dbg_pulses - n0, 32'h1);
    endtask

    task automatic t_status;
        logic [4:0] st [8] = '{ST_SELF_TEST, ST_POWER_UP, ST_DEEP_FAIL_SAFE, ST_INIT_RUN, ST_NORMAL,
            ST_THERMAL_SHUTDOWN, ST_POWER_DOWN, ST_POWER_ON_RESET};
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk_i);
            fsm_state_i <= st[i];
            rdc("status", OFS_FSM_STATUS, {27'h0, st[i]});
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // main sequence after 8 reset cycles
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_regs();
        t_fault_cfg();
        t_state_cmd();
        t_debug();
        t_status();
        print_verdict();
    end

    // run needs well under 1000 cycles; cut a hang at 20000
    initial
    begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        print_verdict();
    end
endmodule // tb
